// [rtl/fault_handler_defines.vh]
/*
 Constants for the motor driver fault handler: fault type codes,
 clearable and current-cut masks and blink timing.
 Assumes inclusion by bare name from the handler module.
*/
`ifndef FAULT_HANDLER_DEFINES_VH
`define FAULT_HANDLER_DEFINES_VH

// fault kinds, index into the fault input vector
`define FK_OVERHEAT 4'h0
`define FK_OVERLOAD 4'h1
`define FK_OVERSPEED 4'h2
`define FK_PULSE_ERR 4'h3
`define FK_REGEN_HOT 4'h4
`define FK_OVERVOLT 4'h5
`define FK_MAINS_ERR 4'h6
`define FK_UNDERVOLT 4'h7
`define FK_OVF_ON 4'h8
`define FK_OVF_OFF 4'h9
`define FK_OVERCURR 4'hA
`define FK_DRIVE_ERR 4'hB
`define FK_BAD_DATA 4'hC
`define FK_GEAR_ERR 4'hD
`define FK_SENSOR_RUN 4'hE
`define FK_SENSOR_INIT 4'hF
`define FK_ROTOR_INIT 5'h10
`define FK_COMBO_ERR 5'h11
`define FK_STORE_ERR 5'h12
`define FAULT_COUNT 19

// kinds that a clear request may release (1 = clearable)
`define FAULT_CLEARABLE_MASK 19'h0330F
// kinds that cut motor current
`define FAULT_CUT_MASK 19'h7EFFF

// blink timing
`define BLINK_ON_MS 200
`define BLINK_OFF_MS 200
`define BLINK_GAP_MS 1200
`define CLOCK_HZ 100000000
`define RESET_CODE 3'h0

`endif

// [rtl/fault_handler.v]
/*
 Fault handler of a pulse-input stepping motor driver: latches
 protective faults, drops the fault-ok output, stops or de-energises
 the motor, drives a 3-bit fault code on shared outputs and blinks
 an indicator with a per-group count.
 Assumes fault inputs and the tool clear command come from logic on
 i_clock; the clear pin comes from outside and is synchronised here.
 Power-on reset is i_rst_n.
*/
//
// Behaviour
// [RULE_01] any fault: fault-ok off, motor stops unless the only fault is bad-data
// [RULE_02] bad-data fault keeps current, motor runs
// [RULE_03] code enable reroutes three outputs to code
// [RULE_04] indicator blinks group count, overvoltage three
// [RULE_05] clear pin acts on ON-to-OFF edge
// [RULE_06] tool clear command acts like pin
// [RULE_07] some faults ignore every clear request
// [RULE_08] power-on reset clears all faults
// [RULE_09] current-cutting faults drop current, brake holds
// [RULE_10] fault stays latched until permitted clear
`timescale 1ns/1ps
`include "fault_handler_defines.vh"

module fault_handler #(
  parameter N = `FAULT_COUNT,
  parameter BLINK_ON_CYCLES = (`BLINK_ON_MS * (`CLOCK_HZ / 1000)),
  parameter BLINK_OFF_CYCLES = (`BLINK_OFF_MS * (`CLOCK_HZ / 1000)),
  parameter BLINK_GAP_CYCLES = (`BLINK_GAP_MS * (`CLOCK_HZ / 1000))
) (
  input wire i_clock,
  input wire i_rst_n,
  input wire [N-1:0] i_fault_detect,
  input wire i_fault_clear_input,
  input wire i_tool_clear,
  input wire i_fault_code_output_enable,
  input wire i_ready,
  input wire i_torque_limit,
  input wire i_timing_pulse,
  input wire i_run_request,
  output reg o_fault_ok_output,
  output reg o_motor_run,
  output reg o_motor_current,
  output reg o_brake_release,
  output reg o_ready_output,
  output reg o_torque_limit_output,
  output reg o_timing_pulse_output,
  output reg o_alarm_led,
  output reg o_fault_active
);

  localparam [N-1:0] CLEARABLE = `FAULT_CLEARABLE_MASK;
  localparam [N-1:0] CUTTING = `FAULT_CUT_MASK;
  localparam S_GAP = 2'h0;
  localparam S_ON = 2'h1;
  localparam S_OFF = 2'h2;

  reg clr_meta;
  reg clr_sync;
  reg clr_prev;
  reg [N-1:0] latched;
  reg [2:0] code;
  reg [3:0] blinks;
  reg [1:0] state;
  reg [3:0] blink_left;
  reg [31:0] timer;
  reg [2:0] next_code;
  reg [3:0] next_blinks;
  integer k;

  wire clear_pin_fall = clr_prev & ~clr_sync;
  wire clear_req = clear_pin_fall | i_tool_clear;
  wire any_fault = |latched;
  wire any_cut = |(latched & CUTTING);

  // two stages before the clear pin is looked at
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_meta <= 1'b0;
      clr_sync <= 1'b0;
      clr_prev <= 1'b0;
    end else begin
      clr_meta <= i_fault_clear_input;
      clr_sync <= clr_meta;
      clr_prev <= clr_sync;
    end
  end

  // fault latch; a new detect wins over a clear in the same cycle
  // [RULE_10] sticky fault latch
  // [RULE_05] falling edge clears
  // [RULE_06] tool clear too
  // [RULE_07] non-clearable kinds kept
  // [RULE_08] reset clears all
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      latched <= {N{1'b0}};
    end else if (clear_req) begin
      latched <= (latched & ~CLEARABLE) | i_fault_detect;
    end else begin
      latched <= latched | i_fault_detect;
    end
  end

  // code and blink group of the lowest latched fault kind
  always @* begin
    next_code = `RESET_CODE;
    next_blinks = 4'h0;
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (latched[k]) begin
        case (k)
          0, 1, 2, 3, 4: begin
            next_code = 3'h2;
            next_blinks = 4'h2;
          end
          5, 6, 7: begin
            next_code = 3'h3;
            next_blinks = 4'h3;
          end
          8, 9, 10: begin
            next_code = 3'h4;
            next_blinks = 4'h4;
          end
          11: begin
            next_code = 3'h5;
            next_blinks = 4'h5;
          end
          12, 13: begin
            next_code = 3'h7;
            next_blinks = 4'h7;
          end
          14, 15, 16, 17: begin
            next_code = 3'h0;
            next_blinks = 4'h8;
          end
          default: begin
            next_code = 3'h1;
            next_blinks = 4'h9;
          end
        endcase
      end
    end
  end

  // [RULE_01] outputs on fault
  // [RULE_02] bad data keeps running
  // [RULE_09] cut current, brake holds
  // [RULE_03] code on shared outputs
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code <= `RESET_CODE;
      blinks <= 4'h0;
      o_fault_ok_output <= 1'b0;
      o_motor_run <= 1'b0;
      o_motor_current <= 1'b0;
      o_brake_release <= 1'b0;
      o_ready_output <= 1'b0;
      o_torque_limit_output <= 1'b0;
      o_timing_pulse_output <= 1'b0;
      o_fault_active <= 1'b0;
    end else begin
      code <= next_code;
      blinks <= next_blinks;
      o_fault_active <= any_fault;
      o_fault_ok_output <= ~any_fault;
      // only a lone bad-data fault lets motion continue
      o_motor_run <= i_run_request & ~any_cut &
        (~any_fault | (latched == (CUTTING ^ {N{1'b1}})));
      o_motor_current <= ~any_cut;
      o_brake_release <= ~any_cut;
      if (i_fault_code_output_enable && any_fault) begin
        o_ready_output <= next_code[0];
        o_torque_limit_output <= next_code[1];
        o_timing_pulse_output <= next_code[2];
      end else begin
        o_ready_output <= i_ready;
        o_torque_limit_output <= i_torque_limit;
        o_timing_pulse_output <= i_timing_pulse;
      end
    end
  end

  // [RULE_04] blink count group
  // a new fault only takes effect at the next group gap
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= S_GAP;
      blink_left <= 4'h0;
      timer <= 32'h0;
      o_alarm_led <= 1'b0;
    end else if (!any_fault) begin
      state <= S_GAP;
      blink_left <= 4'h0;
      timer <= 32'h0;
      o_alarm_led <= 1'b0;
    end else begin
      case (state)
        S_GAP: begin
          o_alarm_led <= 1'b0;
          if (timer >= BLINK_GAP_CYCLES - 1) begin
            timer <= 32'h0;
            blink_left <= blinks;
            state <= S_ON;
            o_alarm_led <= 1'b1;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        S_ON: begin
          if (timer >= BLINK_ON_CYCLES - 1) begin
            timer <= 32'h0;
            o_alarm_led <= 1'b0;
            blink_left <= blink_left - 4'h1;
            state <= S_OFF;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        default: begin
          if (timer >= BLINK_OFF_CYCLES - 1) begin
            timer <= 32'h0;
            if (blink_left == 4'h0) begin
              state <= S_GAP;
            end else begin
              state <= S_ON;
              o_alarm_led <= 1'b1;
            end
          end else begin
            timer <= timer + 32'h1;
          end
        end
      endcase
    end
  end

endmodule

// [tb/fault_handler_checker.sv]
/* checker for fault_handler outputs.
 assumes bind to fault_handler, one clock. */
`timescale 1ns/1ps
module fault_handler_checker #(parameter N = 19) (
  input logic i_clock,
  input logic i_rst_n,
  input logic [N-1:0] i_fault_detect,
  input logic i_fault_clear_input,
  input logic i_tool_clear,
  input logic i_fault_code_output_enable,
  input logic i_ready,
  input logic i_torque_limit,
  input logic i_timing_pulse,
  input logic i_run_request,
  input logic o_fault_ok_output,
  input logic o_motor_run,
  input logic o_motor_current,
  input logic o_brake_release,
  input logic o_ready_output,
  input logic o_torque_limit_output,
  input logic o_timing_pulse_output,
  input logic o_alarm_led,
  input logic o_fault_active
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  AST_OK_LOW:
    assert property (o_fault_active |-> !o_fault_ok_output)
    else $error("ok high in fault");
  AST_LATCH:
    assert property (|i_fault_detect |-> ##2 o_fault_active)
    else $error("fault not latched");
  AST_CAUSE:
    assert property ($rose(o_fault_active) |->
      $past(i_fault_detect, 2) != 0) else $error("fault w/o cause");
  AST_PASS:
    assert property ($past(i_rst_n) && (!o_fault_active ||
      !$past(i_fault_code_output_enable)) |->
      o_ready_output == $past(i_ready)) else $error("no passthrough");
  AST_PASS_TQ:
    assert property ($past(i_rst_n) && (!o_fault_active ||
      !$past(i_fault_code_output_enable)) |->
      o_torque_limit_output == $past(i_torque_limit))
    else $error("torque limit not passed through");
  AST_PASS_TIM:
    assert property ($past(i_rst_n) && (!o_fault_active ||
      !$past(i_fault_code_output_enable)) |->
      o_timing_pulse_output == $past(i_timing_pulse))
    else $error("timing pulse not passed through");
  AST_RUN_REQ:
    assert property ($past(i_rst_n) && !o_fault_active |->
      o_motor_run == $past(i_run_request))
    else $error("run does not follow request");
  AST_RUN:
    assert property (!o_motor_current |-> !o_motor_run)
    else $error("run w/o current");
  AST_BRAKE:
    assert property (!o_motor_current |-> !o_brake_release)
    else $error("brake open w/o current");
  AST_LED:
    assert property (!o_fault_active [*3] |-> !o_alarm_led)
    else $error("led w/o fault");
  AST_CLEAR:
    assert property ($fell(o_fault_active) |->
      $past(i_tool_clear, 2) || !i_fault_clear_input)
    else $error("clear w/o request");
endmodule

// [tb/host_model.sv]
/* host side: drives the clear pin ON then OFF.
 assumes the bench pulses i_go for one cycle. */
`timescale 1ns/1ps
module host_model (
  input wire i_clock,
  input wire i_go,
  output reg o_pin
);
  integer n = 0;
  initial o_pin = 0;
  always @(posedge i_clock) begin
    if (i_go)
      n <= 8;
    else if (n > 0)
      n <= n - 1;
    o_pin <= i_go || n > 1;
  end
endmodule

// [tb/testbench.sv]
/* bench for fault_handler: every kind, code, blinks, clears.
 assumes host_model drives the clear pin. */
`timescale 1ns/1ps
module testbench;
  reg clk = 0, rst_n = 0, tool = 0, en = 1, go = 0;
  reg [18:0] det = 0;
  reg rdy = 0, tq = 0, tim = 0, rq = 0, rq_seen = 0;
  wire pin, ok, run, cur, brk, b0, b1, b2, led, act;
  integer miscompares = 0, cmp_count = 0, k, c, rises = 0;
  reg [31:0] rng = 4208;
  initial forever #5 clk = ~clk;
  fault_handler #(.BLINK_ON_CYCLES(4), .BLINK_OFF_CYCLES(4),
    .BLINK_GAP_CYCLES(10)) fault_handler_i (.i_clock(clk),
    .i_rst_n(rst_n), .i_fault_detect(det), .i_fault_clear_input(pin),
    .i_tool_clear(tool), .i_fault_code_output_enable(en),
    .i_ready(rdy), .i_torque_limit(tq), .i_timing_pulse(tim),
    .i_run_request(rq), .o_fault_ok_output(ok), .o_motor_run(run),
    .o_motor_current(cur), .o_brake_release(brk), .o_ready_output(b0),
    .o_torque_limit_output(b1), .o_timing_pulse_output(b2),
    .o_alarm_led(led), .o_fault_active(act));
  host_model host_model_i (.i_clock(clk), .i_go(go), .o_pin(pin));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  always @(negedge clk) begin
    rng <= xs(rng);
    {rdy, tq, tim} <= rng[2:0];
    rq <= rng[3];
  end
  // request as the design took it at the last edge
  always @(posedge clk) rq_seen <= rq;
  always @(posedge led) rises = rises + 1;
  function [2:0] code(input integer k);
    code = k < 5 ? 2 : k < 8 ? 3 : k < 11 ? 4 : k == 11 ? 5 :
      k < 14 ? 7 : k < 18 ? 0 : 1;
  endfunction
  task chk(input [7:0] g, input [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task reset;
    begin
      rst_n = 0;
      cyc(12);
      rst_n = 1;
      cyc(2);
    end
  endtask
  task test_done;
    begin
      $display("%0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000;
    miscompares = miscompares + 1;
    test_done;
  end
  initial begin
    @(negedge clk);
    reset;
    chk({ok, cur, brk, act}, 8'h0E);
    for (k = 0; k < 19; k = k + 1) begin
      det[k] = 1;
      cyc(1);
      det[k] = 0;
      cyc(4);
      chk({ok, act, b2, b1, b0}, {3'h1, code(k)});
      chk({cur, run, brk}, {k == 12, rq_seen & (k == 12), k == 12});
      c = code(k) < 2 ? code(k) + 8 : code(k);
      en = 0;
      rises = 0;
      cyc(10 + 8 * c);
      chk(rises, c);
      en = 1;
      if (k % 2) begin
        go = 1;
        cyc(1);
        go = 0;
        cyc(6);
        chk(act, 1);
        cyc(12);
      end else begin
        tool = 1;
        cyc(1);
        tool = 0;
        cyc(3);
      end
      c = k < 4 || k == 8 || k == 9 || k == 12 || k == 13;
      chk({act, ok}, c ? 8'h1 : 8'h2);
      reset;
      chk(act, 0);
      $display("kind %0d done", k);
    end
    test_done;
  end
endmodule
bind fault_handler fault_handler_checker #(.N(N)) fault_handler_checker_i (
  .i_clock, .i_rst_n, .i_fault_detect, .i_fault_clear_input,
  .i_tool_clear, .i_fault_code_output_enable, .i_ready,
  .i_torque_limit, .i_timing_pulse, .i_run_request,
  .o_fault_ok_output, .o_motor_run, .o_motor_current, .o_brake_release,
  .o_ready_output, .o_torque_limit_output, .o_timing_pulse_output,
  .o_alarm_led, .o_fault_active);
